// ### pkg/nvm_access_pkg.sv
package nvm_access_pkg;

  // Region select encodings for self-writes.
  localparam logic [1:0] REG_PFM    = 2'h2;
  localparam logic [1:0] REG_EEPROM = 2'h0;

  // Address map, 22-bit table pointer space.
  localparam logic [21:0] PFM_LO    = 22'h000000;
  localparam logic [21:0] PFM_HI    = 22'h01FFFF;
  localparam logic [21:0] UID_LO    = 22'h200000;
  localparam logic [21:0] UID_HI    = 22'h20000F;
  localparam logic [21:0] CFG_LO    = 22'h300000;
  localparam logic [21:0] CFG_HI    = 22'h30000B;
  localparam logic [21:0] EE_LO     = 22'h310000;
  localparam logic [21:0] EE_HI     = 22'h3103FF;
  localparam logic [21:0] ID_LO     = 22'h3FFFFC;
  localparam logic [21:0] ID_HI     = 22'h3FFFFF;
  localparam logic [9:0]  EE_LAST   = 10'h3FF;
  localparam int          UID_WORDS = 8;

  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_ADDR   = 8'h04;
  localparam logic [7:0] A_DATA   = 8'h08;
  localparam logic [7:0] A_STAT   = 8'h0C;
  localparam logic [7:0] A_IRQEN  = 8'h10;
  localparam logic [7:0] A_IRQCLR = 8'h14;
  localparam logic [7:0] A_PROT   = 8'h18;

  // Control register fields.
  localparam int CTRL_WR    = 0;
  localparam int CTRL_RD    = 1;
  localparam int CTRL_ERASE = 2;
  localparam int CTRL_REG0  = 4;
  localparam int CTRL_WRITE_ERROR_FLAG = 8;

  // Status bit positions.
  localparam int ST_DONE  = 0;
  localparam int ST_ERR   = 1;
  localparam int ST_BLOCK = 2;

  // Programming timer.
  localparam int WRITE_TIME_US = 2;
  localparam int CLK_MHZ       = 100;
  localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;

  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    RGN_PFM, RGN_UID, RGN_CFG, RGN_EE, RGN_ID, RGN_NONE
  } region_e;

  // Memory request toward the storage array.
  typedef struct packed {
    logic        we;
    logic [21:0] addr;
    logic [7:0]  data;
  } mem_req_s;

endpackage : nvm_access_pkg

// ### rtl/nvm_access_protection_ctrl.sv
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
module nvm_access_protection_ctrl (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // Protection straps and programmer port.
  input  wire logic        program_code_protect,
  input  wire logic        eeprom_code_protect,
  input  wire logic [7:0]  write_protect_bits,
  input  wire logic        prog_req,
  input  wire logic        prog_we,
  input  wire logic        prog_bulk_erase,
  input  wire logic [21:0] prog_addr,
  input  wire logic [7:0]  prog_wdata,
  output logic [7:0]       prog_rdata_ff,
  output logic             prog_ack_ff,
  // AXI4-Lite write.
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready_ff,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready_ff,
  output logic [1:0]       s_bresp_ff,
  output logic             s_bvalid_ff,
  input  wire logic        s_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready_ff,
  output logic [31:0]      s_rdata_ff,
  output logic [1:0]       s_rresp_ff,
  output logic             s_rvalid_ff,
  input  wire logic        s_rready,
  // Interrupt.
  output logic             irq_ff
);
  typedef enum logic [1:0] {IDLE, BUSY, RDWAIT, PWAIT} st_e;

  st_e                      st_ff;
  logic [1:0]               nvm_region_select;
  logic [21:0]              nvm_address_reg;
  logic [7:0]               nvm_data_reg;
  logic [7:0]               table_latch;
  logic                     wr_ff, rd_ff, erase_ff, write_error_flag;
  logic [2:0]               stat_ff, irqen_ff;
  logic [15:0]              tmr_ff;
  logic                     cp_ff, cpd_ff, bulk_ff;
  logic [7:0]               wrt_ff;
  logic                     aw_ff, w_ff;
  logic [7:0]               awaddr_ff;
  logic [31:0]              wdata_ff;
  logic                     rd_pend_ff, prog_rd_ff;
  logic [2:0]               ev_done, ev_err, ev_block;
  logic                     ps_req0, ps_req1;
  logic                     prog_seen_ff;
  nvm_access_pkg::mem_req_s mreq;
  logic                     mreq_en;
  logic [7:0]               mdata;

  function automatic nvm_access_pkg::region_e decode(input logic [21:0] a);
    if (a <= nvm_access_pkg::PFM_HI) return nvm_access_pkg::RGN_PFM;
    if (a >= nvm_access_pkg::UID_LO && a <= nvm_access_pkg::UID_HI)
      return nvm_access_pkg::RGN_UID;
    if (a >= nvm_access_pkg::CFG_LO && a <= nvm_access_pkg::CFG_HI)
      return nvm_access_pkg::RGN_CFG;
    if (a >= nvm_access_pkg::EE_LO && a <= nvm_access_pkg::EE_HI)
      return nvm_access_pkg::RGN_EE;
    if (a >= nvm_access_pkg::ID_LO) return nvm_access_pkg::RGN_ID;
    return nvm_access_pkg::RGN_NONE;
  endfunction : decode

  // Each write-protect bit covers one eighth of flash.
  function automatic logic flash_locked(input logic [21:0] a, input logic [7:0] w);
    return w[a[16:14]];
  endfunction : flash_locked

  // The bus write decodes to an EEPROM offset when the region select is 00.
  logic [21:0]              wr_addr;
  nvm_access_pkg::region_e  wr_rgn, rd_rgn, pg_rgn;
  logic                     wr_ok, wr_locked;

  always_comb begin
    wr_addr = nvm_address_reg;
    wr_rgn  = nvm_access_pkg::RGN_NONE;
    if (nvm_region_select == nvm_access_pkg::REG_EEPROM) begin
      wr_addr = nvm_access_pkg::EE_LO | {12'h000, nvm_address_reg[9:0]};
      wr_rgn  = (nvm_address_reg[9:0] <= nvm_access_pkg::EE_LAST) ?
                nvm_access_pkg::RGN_EE : nvm_access_pkg::RGN_NONE;
    end else if (nvm_region_select == nvm_access_pkg::REG_PFM) begin
      wr_rgn = (decode(nvm_address_reg) == nvm_access_pkg::RGN_PFM) ?
               nvm_access_pkg::RGN_PFM : nvm_access_pkg::RGN_NONE;
    end else begin
      wr_rgn = decode(nvm_address_reg);
      if (wr_rgn != nvm_access_pkg::RGN_UID && wr_rgn != nvm_access_pkg::RGN_CFG &&
          wr_rgn != nvm_access_pkg::RGN_ID) begin
        wr_rgn = nvm_access_pkg::RGN_NONE;
      end
    end
    // Code protect is deliberately absent here.
    wr_locked = (wr_rgn == nvm_access_pkg::RGN_PFM) &&
                flash_locked(wr_addr, wrt_ff);
    wr_ok = (wr_rgn == nvm_access_pkg::RGN_PFM || wr_rgn == nvm_access_pkg::RGN_UID ||
             wr_rgn == nvm_access_pkg::RGN_CFG || wr_rgn == nvm_access_pkg::RGN_EE) &&
            !wr_locked;
    rd_rgn = decode(nvm_address_reg);
    pg_rgn = decode(prog_addr);
  end

  // Programmer strobe arrives from a pin: two flops, then edge detect on the second.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_req0 <= 1'b0;
      ps_req1 <= 1'b0;
      prog_seen_ff <= 1'b0;
    end else if (ce) begin
      ps_req0 <= prog_req;
      ps_req1 <= ps_req0;
      prog_seen_ff <= ps_req1;
    end
  end

  wire prog_go = ps_req1 && !prog_seen_ff && st_ff == IDLE;
  wire prog_blocked = (pg_rgn == nvm_access_pkg::RGN_PFM && cp_ff) ||
                      (pg_rgn == nvm_access_pkg::RGN_EE && cpd_ff);

  // Straps captured at reset release; a bulk erase wipes protection.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bulk_ff <= 1'b1;
      cp_ff   <= 1'b1;
      cpd_ff  <= 1'b1;
      wrt_ff  <= 8'hFF;
    end else if (ce) begin
      bulk_ff <= 1'b0;
      if (bulk_ff) begin
        cp_ff  <= !program_code_protect;
        cpd_ff <= !eeprom_code_protect;
        wrt_ff <= ~write_protect_bits;
      end else if (prog_go && prog_bulk_erase) begin
        cp_ff  <= 1'b0;
        cpd_ff <= 1'b0;
        wrt_ff <= 8'h00;
      end
    end
  end

  // Sequencer and internal programming timer.
  wire self_start = st_ff == IDLE && !prog_go && (wr_ff || erase_ff) && !write_error_flag;
  wire bad_start  = self_start && !wr_ok;
  wire rd_start   = st_ff == IDLE && !prog_go && rd_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= IDLE;
      tmr_ff <= 16'h0000;
      prog_ack_ff <= 1'b0;
      prog_rdata_ff <= 8'h00;
      prog_rd_ff <= 1'b0;
    end else if (ce) begin
      prog_ack_ff <= 1'b0;
      unique case (st_ff)
        IDLE: begin
          if (prog_go) begin
            prog_rd_ff <= !prog_bulk_erase && !(prog_we && !prog_blocked);
            if (prog_bulk_erase || (prog_we && !prog_blocked)) begin
              st_ff  <= PWAIT;
              tmr_ff <= 16'(nvm_access_pkg::WRITE_CYCLES - 1);
            end else begin
              st_ff <= RDWAIT;
            end
          end else if (self_start && wr_ok) begin
            st_ff  <= BUSY;
            tmr_ff <= 16'(nvm_access_pkg::WRITE_CYCLES - 1);
          end else if (rd_start) begin
            st_ff <= RDWAIT;
          end
        end
        BUSY: begin
          if (tmr_ff == 16'h0000) st_ff <= IDLE;
          else tmr_ff <= tmr_ff - 16'h0001;
        end
        PWAIT: begin
          if (tmr_ff == 16'h0000) begin
            st_ff <= IDLE;
            prog_ack_ff <= 1'b1;
          end else begin
            tmr_ff <= tmr_ff - 16'h0001;
          end
        end
        RDWAIT: begin
          st_ff <= IDLE;
          if (prog_rd_ff) begin
            prog_rdata_ff <= prog_blocked ? 8'h00 : mdata;
            prog_ack_ff <= 1'b1;
            prog_rd_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  // Storage request; programmer takes priority, bulk erase rewrites one location only.
  always_comb begin
    mreq_en = 1'b0;
    mreq    = '0;
    if (prog_go && !(prog_we && prog_blocked)) begin
      mreq_en   = 1'b1;
      mreq.we   = prog_we || prog_bulk_erase;
      mreq.addr = prog_addr;
      mreq.data = prog_bulk_erase ? 8'hFF : prog_wdata;
    end else if (self_start && wr_ok) begin
      mreq_en   = 1'b1;
      mreq.we   = 1'b1;
      mreq.addr = wr_addr;
      mreq.data = erase_ff ? 8'hFF : nvm_data_reg;
    end else if (rd_start) begin
      mreq_en   = 1'b1;
      mreq.addr = nvm_address_reg;
    end
  end

  nvm_store u_store (
    .aclk     (aclk),
    .ce       (ce),
    .req_en   (mreq_en),
    .req      (mreq),
    .rdata_ff (mdata)
  );

  // Event vector: done, error, blocked programmer access.
  always_comb begin
    ev_done  = '0;
    ev_err   = '0;
    ev_block = '0;
    ev_done[nvm_access_pkg::ST_DONE] = st_ff == BUSY && tmr_ff == 16'h0000;
    ev_err[nvm_access_pkg::ST_ERR]   = bad_start;
    ev_block[nvm_access_pkg::ST_BLOCK] = prog_go && prog_blocked;
  end

  wire bus_w = aw_ff && w_ff && !s_bvalid_ff;

  // Software registers; a start bit is cleared by hardware on completion or error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nvm_region_select <= 2'h0;
      nvm_address_reg <= 22'h000000;
      nvm_data_reg <= 8'h00;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      erase_ff <= 1'b0;
      write_error_flag <= 1'b0;
      irqen_ff <= 3'h0;
    end else if (ce) begin
      if (bus_w && awaddr_ff == nvm_access_pkg::A_CTRL && s_wstrb[0]) begin
        wr_ff    <= wdata_ff[nvm_access_pkg::CTRL_WR];
        rd_ff    <= wdata_ff[nvm_access_pkg::CTRL_RD];
        erase_ff <= wdata_ff[nvm_access_pkg::CTRL_ERASE];
        nvm_region_select <= wdata_ff[nvm_access_pkg::CTRL_REG0 +: 2];
      end
      if (bus_w && awaddr_ff == nvm_access_pkg::A_CTRL && s_wstrb[1])
        write_error_flag <= wdata_ff[nvm_access_pkg::CTRL_WRITE_ERROR_FLAG];
      if (bus_w && awaddr_ff == nvm_access_pkg::A_ADDR) nvm_address_reg <= wdata_ff[21:0];
      if (bus_w && awaddr_ff == nvm_access_pkg::A_DATA) nvm_data_reg <= wdata_ff[7:0];
      if (bus_w && awaddr_ff == nvm_access_pkg::A_IRQEN) irqen_ff <= wdata_ff[2:0];
      if (bad_start) begin
        write_error_flag <= 1'b1;
        wr_ff <= 1'b0;
        erase_ff <= 1'b0;
      end
      if (ev_done[nvm_access_pkg::ST_DONE]) begin
        wr_ff <= 1'b0;
        erase_ff <= 1'b0;
      end
      if (st_ff == RDWAIT && !prog_rd_ff) rd_ff <= 1'b0;
    end
  end

  // Table latch takes read data; unsupported regions read as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      table_latch <= 8'h00;
    end else if (ce && st_ff == RDWAIT && !prog_rd_ff) begin
      table_latch <= (rd_rgn == nvm_access_pkg::RGN_NONE) ? 8'h00 : mdata;
    end
  end

  // Sticky status; a set in the same cycle as a clear wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= 3'h0;
      irq_ff  <= 1'b0;
    end else if (ce) begin
      stat_ff <= (stat_ff & ~((bus_w && awaddr_ff == nvm_access_pkg::A_IRQCLR) ?
                 wdata_ff[2:0] : 3'h0)) | ev_done | ev_err | ev_block;
      irq_ff  <= |(stat_ff & irqen_ff);
    end
  end

  // AXI4-Lite write channel: address and data accepted in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      s_awready_ff <= 1'b0;
      s_wready_ff <= 1'b0;
      s_bvalid_ff <= 1'b0;
      s_bresp_ff <= nvm_access_pkg::AXI_OKAY;
    end else if (ce) begin
      s_awready_ff <= !aw_ff && !s_awready_ff && s_awvalid;
      s_wready_ff  <= !w_ff && !s_wready_ff && s_wvalid;
      if (s_awready_ff && s_awvalid) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_awaddr;
      end
      if (s_wready_ff && s_wvalid) begin
        w_ff <= 1'b1;
        wdata_ff <= s_wdata;
      end
      if (bus_w) begin
        s_bvalid_ff <= 1'b1;
        s_bresp_ff <= (awaddr_ff <= nvm_access_pkg::A_PROT && awaddr_ff[1:0] == 2'h0 &&
                       awaddr_ff != nvm_access_pkg::A_STAT && awaddr_ff !=
                       nvm_access_pkg::A_PROT) ? nvm_access_pkg::AXI_OKAY :
                       nvm_access_pkg::AXI_SLVERR;
      end
      if (s_bvalid_ff && s_bready) begin
        s_bvalid_ff <= 1'b0;
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready_ff <= 1'b0;
      s_rvalid_ff <= 1'b0;
      s_rdata_ff <= 32'h00000000;
      s_rresp_ff <= nvm_access_pkg::AXI_OKAY;
    end else if (ce) begin
      s_arready_ff <= !s_arready_ff && !s_rvalid_ff && s_arvalid;
      if (s_arready_ff && s_arvalid) begin
        s_rvalid_ff <= 1'b1;
        s_rresp_ff <= nvm_access_pkg::AXI_OKAY;
        unique case (s_araddr)
          nvm_access_pkg::A_CTRL: s_rdata_ff <= {23'h0, write_error_flag, 2'h0,
                                   nvm_region_select, st_ff != IDLE, erase_ff, rd_ff, wr_ff};
          nvm_access_pkg::A_ADDR:  s_rdata_ff <= {10'h0, nvm_address_reg};
          nvm_access_pkg::A_DATA:  s_rdata_ff <= {24'h0, table_latch};
          nvm_access_pkg::A_STAT:  s_rdata_ff <= {29'h0, stat_ff};
          nvm_access_pkg::A_IRQEN: s_rdata_ff <= {29'h0, irqen_ff};
          nvm_access_pkg::A_IRQCLR: s_rdata_ff <= 32'h00000000;
          nvm_access_pkg::A_PROT:  s_rdata_ff <= {22'h0, cpd_ff, cp_ff, wrt_ff};
          default: begin
            s_rdata_ff <= 32'h00000000;
            s_rresp_ff <= nvm_access_pkg::AXI_SLVERR;
          end
        endcase
      end else if (s_rvalid_ff && s_rready) begin
        s_rvalid_ff <= 1'b0;
      end
    end
  end

  a_bad_write_err: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && bad_start |=> write_error_flag && !wr_ff) else $error("bad write kept");
  a_timer_len: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st_ff == IDLE && self_start && wr_ok |=> st_ff == BUSY && tmr_ff ==
    16'(nvm_access_pkg::WRITE_CYCLES - 1)) else $error("timer not loaded");
  a_locked_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    self_start && wr_locked |-> !mreq_en || !mreq.we || prog_go) else $error("wp write");
  a_cp_prog_block: assert property (@(posedge aclk) disable iff (!aresetn)
    prog_go && prog_we && prog_blocked |-> !mreq_en) else $error("cp write");
  a_uid_free: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_rgn == nvm_access_pkg::RGN_UID |-> !wr_locked) else $error("uid locked");
  a_id_readonly: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_rgn == nvm_access_pkg::RGN_ID |-> !wr_ok) else $error("id writable");
  a_bulk_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && !bulk_ff && prog_go && prog_bulk_erase |=> !cp_ff && !cpd_ff && wrt_ff == 8'h00)
    else $error("bulk kept protection");
  a_busy_ends: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && st_ff == BUSY && tmr_ff == 16'h0000 |=> st_ff == IDLE && !wr_ff)
    else $error("busy stuck");
endmodule : nvm_access_protection_ctrl

// ### rtl/nvm_store.sv
`timescale 1ns/1ps
module nvm_store (
  // Clock.
  input  wire logic                     aclk,
  input  wire logic                     ce,
  // Request.
  input  wire logic                     req_en,
  input  wire nvm_access_pkg::mem_req_s req,
  // Read data.
  output logic [7:0]                    rdata_ff
);
  // Small backing store; the address is folded so that all regions share it.
  logic [7:0] mem [0:255];

  always_ff @(posedge aclk) begin
    if (ce && req_en) begin
      if (req.we) begin
        mem[req.addr[7:0]] <= req.data;
      end
      rdata_ff <= mem[req.addr[7:0]];
    end
  end
endmodule : nvm_store

// ### test/prog_model.sv
`timescale 1ns/1ps
module prog_model (
  // Clock.
  input  wire logic        aclk,
  // Programmer pins.
  output logic             prog_req,
  output logic             prog_we,
  output logic             prog_bulk_erase,
  output logic [21:0]      prog_addr,
  output logic [7:0]       prog_wdata,
  input  wire logic [7:0]  prog_rdata_ff,
  input  wire logic        prog_ack_ff
);
  initial begin
    prog_req        = 1'b0;
    prog_we         = 1'b0;
    prog_bulk_erase = 1'b0;
    prog_addr       = 22'h000000;
    prog_wdata      = 8'h00;
  end

  // Write, address and data lines are inverted after the ack, request and bulk erase driven low, so a late sample of stale values cannot pass.
  task automatic op(input logic we, input logic bulk, input logic [21:0] addr,
                    input logic [7:0] wd, output logic [7:0] rd, output bit ok);
    int n;
    ok = 1'b0;
    rd = 8'h00;
    @(posedge aclk);
    prog_req        <= 1'b1;
    prog_we         <= we;
    prog_bulk_erase <= bulk;
    prog_addr       <= addr;
    prog_wdata      <= wd;
    for (n = 0; n < 1000; n++) begin
      @(posedge aclk);
      if (prog_ack_ff === 1'b1) begin
        rd = prog_rdata_ff;
        ok = 1'b1;
        break;
      end
    end
    prog_req        <= 1'b0;
    prog_we         <= ~we;
    prog_bulk_erase <= 1'b0;
    prog_addr       <= ~addr;
    prog_wdata      <= ~wd;
    // The pin passes two synchronising flops, so it stays low long enough to be seen.
    repeat (4) @(posedge aclk);
  endtask : op
endmodule : prog_model

// ### test/test_nvm_access_protection_ctrl.sv
`timescale 1ns/1ps
module test_nvm_access_protection_ctrl;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic cpn = 1'b0, cpdn = 1'b0;
  logic [7:0] wpn = 8'hFE;
  logic preq, pwe, pbulk, pack, ack_a, ack_w, bvalid, ar_a, rvalid, irq;
  logic [21:0] paddr;
  logic [7:0] pwd, prd, awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [7:0] pr;
  bit ok;
  int errors = 0, check_count = 0;

  always #5 aclk = ~aclk;

  nvm_access_protection_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .program_code_protect(cpn), .eeprom_code_protect(cpdn), .write_protect_bits(wpn),
    .prog_req(preq), .prog_we(pwe), .prog_bulk_erase(pbulk), .prog_addr(paddr),
    .prog_wdata(pwd), .prog_rdata_ff(prd), .prog_ack_ff(pack),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready_ff(ack_a), .s_wdata(wdata),
    .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready_ff(ack_w), .s_bresp_ff(bresp),
    .s_bvalid_ff(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready_ff(ar_a), .s_rdata_ff(rdata), .s_rresp_ff(rresp), .s_rvalid_ff(rvalid),
    .s_rready(rready), .irq_ff(irq));

  prog_model PM (.aclk(aclk), .prog_req(preq), .prog_we(pwe), .prog_bulk_erase(pbulk),
    .prog_addr(paddr), .prog_wdata(pwd), .prog_rdata_ff(prd), .prog_ack_ff(pack));

  task automatic conclude();
    $display("errors %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h", $time, msg, got);
    end
  endtask : chk

  task automatic stuck();
    errors++;
    $display("unexpected at %0t: no answer", $time);
    conclude();
  endtask : stuck

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 1000; n++) begin
      @(posedge aclk);
      if (ack_a === 1'b1) awvalid <= 1'b0;
      if (ack_w === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (n == 1000) stuck();
    rs = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 1000; n++) begin
      @(posedge aclk);
      if (ar_a === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (n == 1000) stuck();
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd

  // Starts a self-write and polls status until done or error; ctrl returns the control word.
  task automatic self_wr(input logic [1:0] rg, input logic [21:0] a, input logic [7:0] v,
                         output logic [31:0] ctrl);
    int n;
    wr(nvm_access_pkg::A_IRQCLR, 32'h7, r);
    wr(nvm_access_pkg::A_ADDR, {10'h0, a}, r);
    wr(nvm_access_pkg::A_DATA, {24'h0, v}, r);
    wr(nvm_access_pkg::A_CTRL, {26'h0, rg, 4'h1}, r);
    for (n = 0; n < 100; n++) begin
      rd(nvm_access_pkg::A_STAT, d, r);
      if (d[1:0] !== 2'b00) break;
    end
    if (n == 100) stuck();
    rd(nvm_access_pkg::A_CTRL, ctrl, r);
  endtask : self_wr

  // Read with region select deliberately set to a write-only code.
  task automatic self_rd(input logic [21:0] a, output logic [31:0] v);
    wr(nvm_access_pkg::A_ADDR, {10'h0, a}, r);
    wr(nvm_access_pkg::A_CTRL, 32'h22, r);
    repeat (4) @(posedge aclk);
    rd(nvm_access_pkg::A_DATA, v, r);
  endtask : self_rd

  task automatic t_regs();
    rd(nvm_access_pkg::A_PROT, d, r);
    chk(d, 32'h301, "protection straps");
    rd(8'h1C, d, r);
    chk(d, 32'h0, "unmapped read data");
    chk({30'h0, r}, {30'h0, nvm_access_pkg::AXI_SLVERR}, "unmapped read");
    wr(nvm_access_pkg::A_STAT, 32'h7, r);
    chk({30'h0, r}, {30'h0, nvm_access_pkg::AXI_SLVERR}, "status write");
  endtask : t_regs

  task automatic t_self();
    self_wr(nvm_access_pkg::REG_EEPROM, nvm_access_pkg::EE_LO + 22'h5, 8'hA5, d);
    chk(d & 32'h109, 32'h0, "eeprom write ctrl");
    self_rd(nvm_access_pkg::EE_LO + 22'h5, d);
    chk(d & 32'hFF, 32'hA5, "eeprom read back");
    self_wr(2'b01, nvm_access_pkg::UID_LO + 22'h3, 8'h5A, d);
    chk(d & 32'h109, 32'h0, "user id write");
    self_rd(nvm_access_pkg::UID_LO + 22'h3, d);
    chk(d & 32'hFF, 32'h5A, "user id read back");
    self_rd(nvm_access_pkg::UID_HI + 22'h1, d);
    chk(d, 32'h0, "unmapped table read");
  endtask : t_self

  task automatic t_refuse();
    wr(nvm_access_pkg::A_IRQEN, 32'h2, r);
    self_wr(nvm_access_pkg::REG_PFM, 22'h000010, 8'h11, d);
    chk(d & 32'h101, 32'h100, "protected flash write");
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(nvm_access_pkg::A_IRQEN, 32'h0, r);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(nvm_access_pkg::A_IRQEN, 32'h2, r);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(nvm_access_pkg::A_IRQCLR, 32'h2, r);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(nvm_access_pkg::A_CTRL, 32'h0, r);
    self_wr(2'b11, nvm_access_pkg::ID_LO, 8'h77, d);
    chk(d & 32'h101, 32'h100, "id space write");
    wr(nvm_access_pkg::A_CTRL, 32'h0, r);
  endtask : t_refuse

  task automatic t_prog();
    PM.op(1'b0, 1'b0, nvm_access_pkg::EE_LO + 22'h5, 8'h00, pr, ok);
    if (!ok) stuck();
    chk({24'h0, pr}, 32'h0, "protected programmer read");
    rd(nvm_access_pkg::A_STAT, d, r);
    chk(d & 32'h4, 32'h4, "programmer blocked");
    PM.op(1'b1, 1'b0, nvm_access_pkg::EE_LO + 22'h5, 8'h99, pr, ok);
    if (!ok) stuck();
    self_rd(nvm_access_pkg::EE_LO + 22'h5, d);
    chk(d & 32'hFF, 32'hA5, "eeprom kept after blocked write");
    PM.op(1'b0, 1'b1, 22'h000000, 8'h00, pr, ok);
    if (!ok) stuck();
    rd(nvm_access_pkg::A_PROT, d, r);
    chk(d, 32'h0, "protection after erase");
    PM.op(1'b1, 1'b0, 22'h000021, 8'h3C, pr, ok);
    if (!ok) stuck();
    PM.op(1'b0, 1'b0, 22'h000021, 8'h00, pr, ok);
    if (!ok) stuck();
    chk({24'h0, pr}, 32'h3C, "programmer flash");
  endtask : t_prog

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_self();
    t_refuse();
    t_prog();
    conclude();
  end
endmodule : test_nvm_access_protection_ctrl
